// ===== phy_status_interrupt_regs_consts.vh
// Constants for the transceiver status, interrupt and diagnostic registers
`ifndef PHY_STATUS_INTERRUPT_REGS_CONSTS_VH
`define PHY_STATUS_INTERRUPT_REGS_CONSTS_VH

// *********************************************************************
// Register offsets
// *********************************************************************
`define OFS_EXPANDED_RECEIVE_CONTROL 5'h18
`define OFS_INTERRUPT_CONTROL_STATUS 5'h1b
`define OFS_CABLE_DIAGNOSTIC 5'h1d
`define OFS_PHY_STATUS_ONE 5'h1e
`define OFS_PHY_CONTROL_TWO 5'h1f

// *********************************************************************
// Field positions
// *********************************************************************
`define BIT_PREAMBLE_RESTORE 6
`define BIT_DIAG_ENABLE 15
`define BIT_XOVER_SELECT 15
`define BIT_INTR_LEVEL 9

// *********************************************************************
// Reset values
// *********************************************************************
`define RST_EXPANDED_HI 9'h010
`define RST_EXPANDED_LO 6'h01
`define RST_INTR_ENABLE 8'h00
`define RST_INTR_FLAGS 8'h00
`define RST_PHY_CONTROL_TWO 16'h8100

// *********************************************************************
// Serial management frame and receive timing counts
// *********************************************************************
`define MGMT_PREAMBLE_ONES 6'h20
`define MGMT_HEADER_LAST 5'h0b
`define MGMT_DATA_LAST 5'h0f
`define MGMT_OP_READ 2'h2
`define MGMT_OP_WRITE 2'h1
`define RX_PREAMBLE_NIBBLES 4'he

`endif

// ===== preamble_strip.v
// Receive nibble path that optionally removes the 10 Mb/s preamble
`timescale 1ns/1ns
`include "phy_status_interrupt_regs_consts.vh"

module preamble_strip (
   input wire core_clk,
   input wire rst,
   input wire strip_enable,
   input wire rx_in_valid,
   input wire [3:0] rx_in_data,
   output reg rx_out_valid,
   output reg [3:0] rx_out_data
);

   // *****************************************************************
   // Nibble counter since the start of the frame
   // *****************************************************************
   reg [3:0] nibble_count;
   wire in_preamble;

   // Saturating count stops wrap on long frames from re-stripping
   assign in_preamble = (nibble_count < `RX_PREAMBLE_NIBBLES);

   // Count nibbles while valid, restart when the frame ends
   always @(posedge core_clk) begin
      if (rst) begin
         nibble_count <= 4'h0;
      end else if (!rx_in_valid) begin
         nibble_count <= 4'h0;
      end else if (in_preamble) begin
         nibble_count <= nibble_count + 4'h1;
      end
   end

   // Drop the seven preamble bytes so the frame opens with SFD
   always @(posedge core_clk) begin
      if (rst) begin
         rx_out_valid <= 1'b0;
         rx_out_data <= 4'h0;
      end else begin
         rx_out_valid <= rx_in_valid & ~(strip_enable & in_preamble);
         rx_out_data <= rx_in_data;
      end
   end

endmodule

// ===== phy_status_interrupt_regs.v
// Management register bank with serial management slave and interrupt pin
`timescale 1ns/1ns
`include "phy_status_interrupt_regs_consts.vh"

//
// Contract
// - In 10 Mb/s, restore bit 1 keeps preamble, 0 strips seven bytes.
// - Jabber sets its flag; interrupts only when its enable, reset 0, is 1.
// - Receive error sets its flag; interrupts only while enabled.
// - Received page sets its flag; interrupts only while enabled.
// - Parallel detect fault sets its flag; interrupts only while enabled.
// - Partner acknowledge sets its flag; interrupts only while enabled.
// - Link loss sets its flag; interrupts only while enabled.
// - Remote fault sets its flag; interrupts only while enabled.
// - Link up sets its flag; interrupts only while enabled.
// - Low-byte flags are read only, reset to 0, clear when read.
// - Writing 1 starts cable test; bit stays 1 until test ends.
// - After test end, results including 9-bit distance stay valid.
// - Result code 00 normal, 01 open, 10 short, 11 test failed.
// - Short-cable indicator set when cable under ten meters.
// - Read-only pause capability bit, 1 means capable, resets 0.
// - Read-only link, polarity reversed and crossover state bits.
// - Energy-detect bit is 1 while receive pair carries a signal.
// - Isolate bit reads 1 while isolated, 0 in normal operation.
// - Three-bit resolved mode: negotiating, 10 or 100, half or full.
// - Crossover select, reset 1, picks standard method at 1.
// - Interrupt pin active high when level bit 1, low when 0.
module phy_status_interrupt_regs #(
   parameter [4:0] PHY_ADDR = 5'h01
) (
   input wire core_clk,
   input wire rst,
   input wire mdc,
   input wire mdio_in,
   output reg mdio_out,
   output reg mdio_oe,
   output reg intr_pin,
   input wire jabber_event,
   input wire rx_error_event,
   input wire page_received_event,
   input wire parallel_fault_event,
   input wire partner_ack_event,
   input wire link_down_event,
   input wire remote_fault_event,
   input wire link_up_event,
   input wire pause_capable,
   input wire link_is_up,
   input wire polarity_reversed,
   input wire mdix_state,
   input wire energy_present,
   input wire phy_isolated,
   input wire [2:0] operation_mode,
   output reg diag_start,
   input wire diag_done,
   input wire [1:0] diag_result_in,
   input wire diag_short_in,
   input wire [8:0] diag_distance_in,
   output reg preamble_restore,
   output reg crossover_algorithm_select,
   input wire rx_in_valid,
   input wire [3:0] rx_in_data,
   output wire rx_out_valid,
   output wire [3:0] rx_out_data
);

   // *****************************************************************
   // Frame states
   // *****************************************************************
   localparam [2:0] ST_PREAMBLE = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_HEADER = 3'h2;
   localparam [2:0] ST_TURN_ONE = 3'h3;
   localparam [2:0] ST_TURN_TWO = 3'h4;
   localparam [2:0] ST_DATA = 3'h5;
   localparam [15:0] RESET_TWO = `RST_PHY_CONTROL_TWO;

   // *****************************************************************
   // Pin synchronisers and clock edge detection
   // *****************************************************************
   reg mdc_meta;
   reg mdc_sync;
   reg mdc_last;
   reg mdio_meta;
   reg mdio_sync;
   wire mdc_rise;

   // Two flops per pin; the management clock is slow enough to sample
   always @(posedge core_clk) begin
      if (rst) begin
         mdc_meta <= 1'b0;
         mdc_sync <= 1'b0;
         mdc_last <= 1'b0;
         mdio_meta <= 1'b1;
         mdio_sync <= 1'b1;
      end else begin
         mdc_meta <= mdc;
         mdc_sync <= mdc_meta;
         mdc_last <= mdc_sync;
         mdio_meta <= mdio_in;
         mdio_sync <= mdio_meta;
      end
   end

   assign mdc_rise = mdc_sync & ~mdc_last;

   // *****************************************************************
   // Register storage
   // *****************************************************************
   reg [15:7] expanded_hi;
   reg [7:0] intr_enable;
   reg [7:0] intr_flags;
   reg [1:0] diag_result;
   reg diag_short;
   reg [2:0] diag_reserved;
   reg [8:0] diag_distance;
   reg [14:0] control_two_rest;
   wire [7:0] events;
   wire [15:0] read_word;

   // Bit order matches the flag byte, jabber at the top
   assign events = {jabber_event, rx_error_event, page_received_event,
                    parallel_fault_event, partner_ack_event,
                    link_down_event, remote_fault_event, link_up_event};

   // Word seen by the station for a given register offset
   function [15:0] register_value;
      input [4:0] addr;
      begin
         case (addr)
            `OFS_EXPANDED_RECEIVE_CONTROL: register_value =
               {expanded_hi, preamble_restore, `RST_EXPANDED_LO};
            `OFS_INTERRUPT_CONTROL_STATUS: register_value =
               {intr_enable, intr_flags};
            `OFS_CABLE_DIAGNOSTIC: register_value =
               {diag_start, diag_result, diag_short, diag_reserved,
                diag_distance};
            `OFS_PHY_STATUS_ONE: register_value =
               {6'h00, pause_capable, link_is_up, polarity_reversed,
                1'b0, mdix_state, energy_present, phy_isolated,
                operation_mode};
            `OFS_PHY_CONTROL_TWO: register_value =
               {crossover_algorithm_select, control_two_rest};
            default: register_value = 16'h0000;
         endcase
      end
   endfunction

   // *****************************************************************
   // Serial management frame engine
   // *****************************************************************
   reg [2:0] state;
   reg [5:0] ones_count;
   reg [4:0] bit_count;
   reg [10:0] header;
   reg [15:0] shift;
   reg is_read;
   reg addr_ok;
   reg [4:0] target;
   wire header_done;
   wire [4:0] decode_addr;
   wire decode_read;
   wire decode_ok;
   wire read_clear;
   wire write_fire;
   wire [15:0] write_data;

   assign header_done = mdc_rise && state == ST_HEADER &&
                        bit_count == `MGMT_HEADER_LAST;
   assign decode_addr = {header[3:0], mdio_sync};
   assign decode_read = header[10:9] == `MGMT_OP_READ;
   assign decode_ok = header[8:4] == PHY_ADDR &&
                      (decode_read || header[10:9] == `MGMT_OP_WRITE);
   assign read_word = register_value(decode_addr);
   // Clearing at the sampling edge means nothing seen is ever lost
   assign read_clear = header_done && decode_ok && decode_read &&
                       decode_addr == `OFS_INTERRUPT_CONTROL_STATUS;
   assign write_fire = mdc_rise && state == ST_DATA && !is_read &&
                       addr_ok && bit_count == `MGMT_DATA_LAST;
   assign write_data = {shift[14:0], mdio_sync};

   // Bits are taken and driven on the rising management clock edge
   always @(posedge core_clk) begin
      if (rst) begin
         state <= ST_PREAMBLE;
         ones_count <= 6'h00;
         bit_count <= 5'h00;
         header <= 11'h000;
         shift <= 16'h0000;
         is_read <= 1'b0;
         addr_ok <= 1'b0;
         target <= 5'h00;
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
      end else if (mdc_rise) begin
         case (state)
            ST_PREAMBLE: begin
               if (mdio_sync) begin
                  if (ones_count != `MGMT_PREAMBLE_ONES) begin
                     ones_count <= ones_count + 6'h01;
                  end
               end else begin
                  if (ones_count == `MGMT_PREAMBLE_ONES) begin
                     state <= ST_START;
                  end
                  ones_count <= 6'h00;
               end
            end
            ST_START: begin
               bit_count <= 5'h00;
               state <= mdio_sync ? ST_HEADER : ST_PREAMBLE;
            end
            ST_HEADER: begin
               header <= {header[9:0], mdio_sync};
               bit_count <= bit_count + 5'h01;
               if (bit_count == `MGMT_HEADER_LAST) begin
                  is_read <= decode_read;
                  addr_ok <= decode_ok;
                  target <= decode_addr;
                  shift <= read_word;
                  state <= ST_TURN_ONE;
               end
            end
            ST_TURN_ONE: begin
               // Station releases the line first; drive zero afterwards
               mdio_out <= 1'b0;
               mdio_oe <= is_read & addr_ok;
               state <= ST_TURN_TWO;
            end
            ST_TURN_TWO: begin
               mdio_out <= shift[15];
               if (is_read) begin
                  shift <= {shift[14:0], 1'b0};
               end
               bit_count <= 5'h00;
               state <= ST_DATA;
            end
            ST_DATA: begin
               bit_count <= bit_count + 5'h01;
               if (bit_count == `MGMT_DATA_LAST) begin
                  mdio_oe <= 1'b0;
                  mdio_out <= 1'b0;
                  state <= ST_PREAMBLE;
               end else if (is_read) begin
                  mdio_out <= shift[15];
                  shift <= {shift[14:0], 1'b0};
               end else begin
                  shift <= write_data;
               end
            end
            default: begin
               state <= ST_PREAMBLE;
               mdio_oe <= 1'b0;
            end
         endcase
      end
   end

   // *****************************************************************
   // Control registers written by the station
   // *****************************************************************
   always @(posedge core_clk) begin
      if (rst) begin
         expanded_hi <= `RST_EXPANDED_HI;
         preamble_restore <= 1'b0;
         intr_enable <= `RST_INTR_ENABLE;
         control_two_rest <= RESET_TWO[14:0];
         crossover_algorithm_select <= RESET_TWO[15];
      end else if (write_fire) begin
         case (target)
            `OFS_EXPANDED_RECEIVE_CONTROL: begin
               expanded_hi <= write_data[15:7];
               preamble_restore <= write_data[`BIT_PREAMBLE_RESTORE];
            end
            `OFS_INTERRUPT_CONTROL_STATUS: begin
               intr_enable <= write_data[15:8];
            end
            `OFS_PHY_CONTROL_TWO: begin
               // Standard method at 1, alternative method at 0
               crossover_algorithm_select <=
                  write_data[`BIT_XOVER_SELECT];
               control_two_rest <= write_data[14:0];
            end
            default: begin
               preamble_restore <= preamble_restore;
            end
         endcase
      end
   end

   // *****************************************************************
   // Event flags, cleared by reading, set taking priority
   // *****************************************************************
   always @(posedge core_clk) begin
      if (rst) begin
         intr_flags <= `RST_INTR_FLAGS;
      end else begin
         intr_flags <= (intr_flags & ~{8{read_clear}}) | events;
      end
   end

   // *****************************************************************
   // Cable diagnostic start and results
   // *****************************************************************
   always @(posedge core_clk) begin
      if (rst) begin
         diag_start <= 1'b0;
         diag_result <= 2'h0;
         diag_short <= 1'b0;
         diag_reserved <= 3'h0;
         diag_distance <= 9'h000;
      end else begin
         if (write_fire && target == `OFS_CABLE_DIAGNOSTIC) begin
            diag_reserved <= write_data[11:9];
            // A fresh start overrides a completion in the same cycle
            if (write_data[`BIT_DIAG_ENABLE]) begin
               diag_start <= 1'b1;
            end else if (diag_done) begin
               diag_start <= 1'b0;
            end
         end else if (diag_done && diag_start) begin
            diag_start <= 1'b0;
         end
         if (diag_done && diag_start) begin
            // Results are frozen until the next test completes
            diag_result <= diag_result_in;
            diag_short <= diag_short_in;
            diag_distance <= diag_distance_in;
         end
      end
   end

   // *****************************************************************
   // Interrupt pin with selectable polarity
   // *****************************************************************
   wire intr_active;

   assign intr_active = |(intr_enable & intr_flags);

   // Reset value matches the active-low default, so the pin idles high
   always @(posedge core_clk) begin
      if (rst) begin
         intr_pin <= 1'b1;
      end else begin
         intr_pin <= control_two_rest[`BIT_INTR_LEVEL] ?
                     intr_active : ~intr_active;
      end
   end

   // *****************************************************************
   // Receive preamble handling
   // *****************************************************************
   wire strip_enable;

   // Only 10 Mb/s frames lose their preamble; 100 Mb/s always keeps it
   assign strip_enable = ~preamble_restore &
                         (operation_mode[1:0] == 2'h1);

   preamble_strip u_preamble_strip (
      .core_clk(core_clk),
      .rst(rst),
      .strip_enable(strip_enable),
      .rx_in_valid(rx_in_valid),
      .rx_in_data(rx_in_data),
      .rx_out_valid(rx_out_valid),
      .rx_out_data(rx_out_data)
   );

endmodule

// ===== phy_status_interrupt_regs_checker.sv
// Port-level assertions for the management register bank
`timescale 1ns/1ns
// *********************************************************************
// Checker
// *********************************************************************
module phy_status_interrupt_regs_checker (
   input wire core_clk,
   input wire rst,
   input wire mdio_out,
   input wire mdio_oe,
   input wire intr_pin,
   input wire [2:0] operation_mode,
   input wire diag_start,
   input wire diag_done,
   input wire preamble_restore,
   input wire crossover_algorithm_select,
   input wire rx_in_valid,
   input wire [3:0] rx_in_data,
   input wire rx_out_valid,
   input wire [3:0] rx_out_data
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   reg [7:0] oe_run;
   // Counts answer cycles; a fixed-repetition would be far too long here
   always @(posedge core_clk) begin
      if (rst || !mdio_oe) oe_run <= 8'h00;
      else oe_run <= oe_run + 8'h01;
   end
   sequence s_strip_start;
      rx_in_valid && !$past(rx_in_valid) && !preamble_restore &&
         operation_mode[1:0] == 2'b01;
   endsequence
   sequence s_answer_head;
      !mdio_out ##1 mdio_oe[*7];
   endsequence
   property p_reset_state;
      disable iff (1'b0) rst |=> !mdio_oe && intr_pin && !diag_start &&
         crossover_algorithm_select && !preamble_restore && !rx_out_valid;
   endproperty
   property p_strip_hide;
      s_strip_start |=> !rx_out_valid[*7] ##1 !rx_out_valid[*7];
   endproperty
   property p_strip_show;
      s_strip_start ##1 rx_in_valid[*8] ##1 rx_in_valid[*6] |=> rx_out_valid;
   endproperty
   property p_pass;
      preamble_restore ##1 preamble_restore |->
         rx_out_valid == $past(rx_in_valid);
   endproperty
   property p_data_flow;
      1'b1 |=> rx_out_data == $past(rx_in_data);
   endproperty
   property p_diag_hold;
      diag_start && !diag_done |=> diag_start;
   endproperty
   property p_diag_end;
      diag_start && diag_done |=> !diag_start;
   endproperty
   property p_ta_zero;
      $rose(mdio_oe) |-> s_answer_head;
   endproperty
   property p_answer_len;
      $fell(mdio_oe) |-> oe_run inside {[8'h85:8'h8b]};
   endproperty
   property p_answer_end;
      mdio_oe |-> oe_run < 8'h8c;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("reset state wrong");
   a_strip_hide: assert property (p_strip_hide)
      else $error("preamble nibble shown");
   a_strip_show: assert property (p_strip_show)
      else $error("frame nibble hidden");
   a_pass: assert property (p_pass)
      else $error("preamble not kept");
   a_data_flow: assert property (p_data_flow)
      else $error("receive data lost");
   a_diag_hold: assert property (p_diag_hold)
      else $error("test ended early");
   a_diag_end: assert property (p_diag_end)
      else $error("test not ended");
   a_ta_zero: assert property (p_ta_zero)
      else $error("turnaround bad");
   a_answer_len: assert property (p_answer_len)
      else $error("answer length bad");
   a_answer_end: assert property (p_answer_end)
      else $error("answer too long");
endmodule
bind phy_status_interrupt_regs phy_status_interrupt_regs_checker u_chk (
   .core_clk(core_clk), .rst(rst), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
   .intr_pin(intr_pin), .operation_mode(operation_mode),
   .diag_start(diag_start), .diag_done(diag_done),
   .preamble_restore(preamble_restore),
   .crossover_algorithm_select(crossover_algorithm_select),
   .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
   .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data));

// ===== mgmt_station.sv
// Station management controller model that runs serial frames
`timescale 1ns/1ns
// *********************************************************************
// Station
// *********************************************************************
module mgmt_station (
   output reg mdc = 1'b0,
   output reg mdio_drv = 1'b0,
   output reg mdio_en = 1'b0,
   input wire mdio_line,
   output reg rd_valid = 1'b0,
   output reg [15:0] rd_word = 16'h0000
);
   // One bit: change after the fall, sample just before the rise
   task automatic tick(input reg en, input reg b, output reg s);
      mdio_en = en;
      mdio_drv = b;
      #400 s = mdio_line;
      mdc = 1'b1;
      #400 mdc = 1'b0;
   endtask
   // Whole frame; clock stands low afterwards, line released
   task automatic xfer(input reg rd, input [4:0] pa, input [4:0] ra,
         input [15:0] wd);
      reg [31:0] f;
      reg s;
      integer k;
      f = {2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
      #33;
      for (k = 0; k < 32; k++) tick(1'b1, 1'b1, s);
      for (k = 31; k >= 0; k--) begin
         tick(!rd || k > 17, f[k], s);
         if (k < 16) rd_word[k] = s;
      end
      mdio_en = 1'b0;
      rd_valid = rd;
      #1 rd_valid = 1'b0;
   endtask
endmodule

// ===== phy_status_interrupt_regs_tb_top.sv
// Self-checking bench for the management register bank
`timescale 1ns/1ns
`include "phy_status_interrupt_regs_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
   fail_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
// *********************************************************************
// Bench
// *********************************************************************
module phy_status_interrupt_regs_tb_top;
   reg core_clk = 1'b0;
   reg rst = 1'b1;
   reg [7:0] ev = 8'h00;
   reg pause = 0, link = 0, pol = 0, mdix = 0, energy = 0, iso = 0;
   reg done = 0, dshort = 0, rxv = 0;
   reg [2:0] mode = 3'h0;
   reg [1:0] dres = 2'h0;
   reg [8:0] ddist = 9'h000;
   reg [3:0] rxd = 4'h0;
   reg [15:0] lfsr = 16'h83f2;
   reg [15:0] e, x;
   reg [15:0] exp_q[$];
   int fail_count = 0, check_count = 0, i, n;
   wire mdc, st_drv, st_en, rd_valid, mdio_out, mdio_oe, intr_pin;
   wire diag_start, restore, xsel, rxov;
   wire [3:0] rxod;
   wire [15:0] rd_word;
   // Pull-up holds the line high when nobody drives it
   wire mdio_line = mdio_oe ? mdio_out : (st_en ? st_drv : 1'b1);
   phy_status_interrupt_regs dut (.core_clk(core_clk), .rst(rst),
      .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .intr_pin(intr_pin), .jabber_event(ev[7]),
      .rx_error_event(ev[6]), .page_received_event(ev[5]),
      .parallel_fault_event(ev[4]), .partner_ack_event(ev[3]),
      .link_down_event(ev[2]), .remote_fault_event(ev[1]),
      .link_up_event(ev[0]), .pause_capable(pause), .link_is_up(link),
      .polarity_reversed(pol), .mdix_state(mdix), .energy_present(energy),
      .phy_isolated(iso), .operation_mode(mode), .diag_start(diag_start),
      .diag_done(done), .diag_result_in(dres), .diag_short_in(dshort),
      .diag_distance_in(ddist), .preamble_restore(restore),
      .crossover_algorithm_select(xsel), .rx_in_valid(rxv),
      .rx_in_data(rxd), .rx_out_valid(rxov), .rx_out_data(rxod));
   mgmt_station st (.mdc(mdc), .mdio_drv(st_drv), .mdio_en(st_en),
      .mdio_line(mdio_line), .rd_valid(rd_valid), .rd_word(rd_word));
   // Clock
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   function automatic [15:0] nxt(input [15:0] s);
      nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task step;
      @(posedge core_clk);
      #1;
   endtask
   task rd(input [4:0] pa, input [4:0] ra, input [15:0] v);
      exp_q.push_back(v);
      st.xfer(1'b1, pa, ra, 16'h0000);
      // Realign so later stimulus lands just after a core edge
      step;
   endtask
   // Extra cycles let the write reach the outputs before any check
   task wr(input [4:0] ra, input [15:0] d);
      st.xfer(1'b0, 5'h01, ra, d);
      repeat (4) step;
   endtask
   task pulse(input [7:0] m);
      step;
      ev = m;
      step;
      ev = 8'h00;
      repeat (3) step;
   endtask
   task burst(output int cnt);
      cnt = 0;
      for (int k = 0; k < 22; k++) begin
         step;
         rxv = (k < 20);
         lfsr = nxt(lfsr);
         rxd = lfsr[3:0];
         cnt += rxov;
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Every read answer is matched against the oldest expectation
   always @(posedge rd_valid) begin
      e = exp_q.pop_front();
      `CHK(rd_word, e)
   end
   // Watchdog sized well beyond the frame count
   initial begin
      #8000000;
      fail_count++;
      conclude;
   end
   // Main sequence
   initial begin
      repeat (6) step;
      rst = 1'b0;
      repeat (3) step;
      `CHK(intr_pin, 1'b1)
      `CHK(xsel, 1'b1)
      rd(5'h01, `OFS_EXPANDED_RECEIVE_CONTROL, 16'h0801);
      rd(5'h01, `OFS_INTERRUPT_CONTROL_STATUS, 16'h0000);
      rd(5'h01, `OFS_CABLE_DIAGNOSTIC, 16'h0000);
      rd(5'h01, `OFS_PHY_CONTROL_TWO, 16'h8100);
      rd(5'h01, 5'h10, 16'h0000);
      rd(5'h02, `OFS_PHY_CONTROL_TWO, 16'hffff);
      wr(`OFS_PHY_STATUS_ONE, 16'hffff);
      for (i = 0; i < 3; i++) begin
         lfsr = nxt(lfsr);
         {pause, link, pol, mdix, energy, iso, mode} = lfsr[8:0];
         x = {6'h00, lfsr[8:6], 1'b0, lfsr[5:0]};
         rd(5'h01, `OFS_PHY_STATUS_ONE, x);
      end
      pulse(8'hff);
      `CHK(intr_pin, 1'b1)
      rd(5'h01, `OFS_INTERRUPT_CONTROL_STATUS, 16'h00ff);
      rd(5'h01, `OFS_INTERRUPT_CONTROL_STATUS, 16'h0000);
      for (i = 0; i < 8; i++) begin
         n = (i + 1) % 8;
         wr(`OFS_INTERRUPT_CONTROL_STATUS, 16'h00ff | (16'h0100 << i));
         pulse(8'h01 << n);
         `CHK(intr_pin, 1'b1)
         pulse(8'h01 << i);
         `CHK(intr_pin, 1'b0)
         x = (16'h0101 << i) | (16'h0001 << n);
         rd(5'h01, `OFS_INTERRUPT_CONTROL_STATUS, x);
         `CHK(intr_pin, 1'b1)
      end
      wr(`OFS_PHY_CONTROL_TWO, 16'h0300);
      `CHK(intr_pin, 1'b0)
      `CHK(xsel, 1'b0)
      pulse(8'h80);
      `CHK(intr_pin, 1'b1)
      rd(5'h01, `OFS_INTERRUPT_CONTROL_STATUS, 16'h8080);
      `CHK(intr_pin, 1'b0)
      rd(5'h01, `OFS_PHY_CONTROL_TWO, 16'h0300);
      // Results of the previous test stay visible while a new one runs
      x = 16'h0e00;
      for (i = 0; i < 4; i++) begin
         wr(`OFS_CABLE_DIAGNOSTIC, 16'h8e00);
         `CHK(diag_start, 1'b1)
         rd(5'h01, `OFS_CABLE_DIAGNOSTIC, x | 16'h8000);
         lfsr = nxt(lfsr);
         {dshort, ddist} = lfsr[9:0];
         dres = i[1:0];
         x = {1'b0, i[1:0], lfsr[9], 3'h7, lfsr[8:0]};
         done = 1'b1;
         step;
         done = 1'b0;
         ddist = ~ddist;
         dshort = ~dshort;
         step;
         `CHK(diag_start, 1'b0)
         rd(5'h01, `OFS_CABLE_DIAGNOSTIC, x);
      end
      mode = 3'h1;
      burst(n);
      `CHK(n, 6)
      wr(`OFS_EXPANDED_RECEIVE_CONTROL, 16'h0840);
      `CHK(restore, 1'b1)
      rd(5'h01, `OFS_EXPANDED_RECEIVE_CONTROL, 16'h0841);
      burst(n);
      `CHK(n, 20)
      wr(`OFS_EXPANDED_RECEIVE_CONTROL, 16'h0800);
      mode = 3'h5;
      burst(n);
      `CHK(n, 6)
      mode = 3'h2;
      burst(n);
      `CHK(n, 20)
      conclude;
   end
endmodule
